// ---- ccr_config_bank.sv ----
`timescale 1ns/100ps
module ccr_config_bank #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a      // arbitrary value
) (
   input  wire logic           clk,              // 125 MHz
   input  wire logic           reset_n,          // async, active low
   input  wire logic           scl_in,           // serial clock
   input  wire logic           sda_in,           // serial data level
   output logic                sda_out,          // serial data drive value
   output logic                sda_oe_n,         // low while pulling data low
   input  wire logic           watchdog_expiry,  // one-cycle pulse
   input  wire logic [7:0]     sys_status,       // live status byte
   output ccr_pkg::ccr_cfg_s   cfg,              // configuration fields
   output logic                wd_restart        // one-cycle restart pulse
);
   import ccr_pkg::*;

   logic [7:0] bank_reg [0:CCR_NREG-1];
   ccr_state_e state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] sh_reg;
   logic [7:0] ptr_reg;
   logic       is_rd_reg;
   logic       nack_reg;
   logic       oe_n_reg;
   logic       sda_out_reg;
   logic       scl_q_reg;
   logic       sda_q_reg;
   logic       wr_go_reg;
   logic [7:0] wr_ptr_reg;
   logic [7:0] wr_data_reg;
   logic       wd_restart_reg;
   logic       first_reg;
   logic [7:0] rd_byte;
   logic       start_c;
   logic       stop_c;
   logic       scl_rise;
   logic       scl_fall;
   logic       restore_go;

   // pins are synchronous, so one stage of history suffices for edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_in;
         sda_q_reg <= sda_in;
      end
   end

   assign start_c  = scl_q_reg && scl_in && sda_q_reg && !sda_in;
   assign stop_c   = scl_q_reg && scl_in && !sda_q_reg && sda_in;
   assign scl_rise = !scl_q_reg && scl_in;
   assign scl_fall = scl_q_reg && !scl_in;

   always_comb begin
      if (ptr_reg < 8'(CCR_NREG)) begin
         rd_byte = bank_reg[ptr_reg[3:0]];
      end else if (ptr_reg == CCR_A_ADDR) begin
         rd_byte = CCR_ADDR_VAL;
      end else begin
         rd_byte = 8'h00;
      end
   end

   // serial protocol engine; the bus master owns the clock, no stretching
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 4'h0;
         sh_reg      <= 8'h00;
         ptr_reg     <= 8'h00;
         is_rd_reg   <= 1'b0;
         nack_reg    <= 1'b0;
         oe_n_reg    <= 1'b1;
         wr_go_reg   <= 1'b0;
         wr_ptr_reg  <= 8'h00;
         wr_data_reg <= 8'h00;
      end else begin
         wr_go_reg <= 1'b0;
         if (start_c) begin
            state_reg <= ST_DEV;
            cnt_reg   <= 4'h0;
            oe_n_reg  <= 1'b1;
         end else if (stop_c) begin
            state_reg <= ST_IDLE;
            oe_n_reg  <= 1'b1;
         end else if (scl_rise) begin
            case (state_reg)
               ST_DEV, ST_PTR, ST_WR: begin
                  sh_reg  <= {sh_reg[6:0], sda_in};
                  cnt_reg <= cnt_reg + 4'h1;
               end
               ST_RD: begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
               ST_RD_ACK: begin
                  // pointer moves only on the master's ack, so a nack leaves it in place
                  nack_reg <= sda_in;
                  if (!sda_in) begin
                     ptr_reg <= ptr_reg + 8'h01;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state_reg)
               ST_DEV: begin
                  if (cnt_reg == CCR_BITS) begin
                     if (sh_reg[7:1] == SLAVE_ADDR) begin
                        state_reg <= ST_DEV_ACK;
                        oe_n_reg  <= 1'b0;
                        is_rd_reg <= sh_reg[0];
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_DEV_ACK: begin
                  cnt_reg <= 4'h0;
                  if (is_rd_reg) begin
                     state_reg <= ST_RD;
                     sh_reg    <= rd_byte;
                     oe_n_reg  <= rd_byte[7];
                  end else begin
                     state_reg <= ST_PTR;
                     oe_n_reg  <= 1'b1;
                  end
               end
               ST_PTR: begin
                  if (cnt_reg == CCR_BITS) begin
                     ptr_reg   <= sh_reg;
                     state_reg <= ST_PTR_ACK;
                     oe_n_reg  <= 1'b0;
                  end
               end
               ST_PTR_ACK, ST_WR_ACK: begin
                  state_reg <= ST_WR;
                  cnt_reg   <= 4'h0;
                  oe_n_reg  <= 1'b1;
               end
               ST_WR: begin
                  if (cnt_reg == CCR_BITS) begin
                     state_reg   <= ST_WR_ACK;
                     oe_n_reg    <= 1'b0;
                     wr_go_reg   <= 1'b1;
                     wr_ptr_reg  <= ptr_reg;
                     wr_data_reg <= sh_reg;
                     ptr_reg     <= ptr_reg + 8'h01;
                  end
               end
               ST_RD: begin
                  if (cnt_reg == CCR_BITS) begin
                     state_reg <= ST_RD_ACK;
                     oe_n_reg  <= 1'b1;
                  end else begin
                     sh_reg   <= {sh_reg[6:0], 1'b0};
                     oe_n_reg <= sh_reg[6];
                  end
               end
               ST_RD_ACK: begin
                  if (nack_reg) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg <= ST_RD;
                     cnt_reg   <= 4'h0;
                     sh_reg    <= rd_byte;
                     oe_n_reg  <= rd_byte[7];
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign restore_go = wr_go_reg && (wr_ptr_reg == CCR_A_CHG) && wr_data_reg[CCR_RST_BIT];

   // register bank; restore outranks watchdog, which outranks a write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CCR_NREG; i++) begin
            bank_reg[i] <= CCR_POR[i];
         end
      end else begin
         bank_reg[CCR_A_STATUS[3:0]] <= sys_status;
         if (restore_go) begin
            for (int i = 0; i < CCR_NREG; i++) begin
               if (i != int'(CCR_A_STATUS)) begin
                  bank_reg[i] <= CCR_POR[i];
               end
            end
         end else if (watchdog_expiry) begin
            for (int i = 0; i < CCR_NREG; i++) begin
               if (i != int'(CCR_A_STATUS)) begin
                  bank_reg[i] <= (bank_reg[i] & ~CCR_WD_MASK[i])
                                 | (CCR_POR[i] & CCR_WD_MASK[i]);
               end
            end
         end else if (wr_go_reg) begin
            case (wr_ptr_reg)
               CCR_A_CHG: begin
                  // action bits are never stored, so they read back as zero
                  bank_reg[CCR_A_CHG[3:0]] <= {2'b00, (wr_data_reg[5:0] > CCR_ICC_MAX) ?
                                              CCR_ICC_MAX : wr_data_reg[5:0]};
               end
               CCR_A_DIS: begin
                  // code 0000 is not a legal cap, lifted to the least legal one
                  bank_reg[CCR_A_DIS[3:0]] <= {(wr_data_reg[7:4] < CCR_DSC_MIN) ?
                                              CCR_DSC_MIN : wr_data_reg[7:4],
                                              wr_data_reg[3:0]};
               end
               CCR_A_STATUS, CCR_A_ADDR: begin
               end
               default: begin
                  if (wr_ptr_reg < 8'(CCR_NREG)) begin
                     bank_reg[wr_ptr_reg[3:0]] <= wr_data_reg;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_restart_reg <= 1'b0;
         sda_out_reg    <= 1'b0;
         first_reg      <= 1'b1;
      end else begin
         wd_restart_reg <= wr_go_reg && (wr_ptr_reg == CCR_A_CHG)
                           && wr_data_reg[CCR_WDR_BIT];
         sda_out_reg    <= 1'b0;
         first_reg      <= 1'b0;
      end
   end

   assign sda_out    = sda_out_reg;
   assign sda_oe_n   = oe_n_reg;
   assign wd_restart = wd_restart_reg;
   assign cfg.vin_floor  = bank_reg[0][7:4];
   assign cfg.iin_cap    = bank_reg[0][3:0];
   assign cfg.disc_hold  = bank_reg[1][7:6];
   assign cfg.off_time   = bank_reg[1][5];
   assign cfg.input_high_impedance_enable    = bank_reg[1][4];
   assign cfg.charge_inhibit                 = bank_reg[1][3];
   assign cfg.battery_undervoltage_threshold = bank_reg[1][2:0];
   assign cfg.fast_chg   = bank_reg[2][5:0];
   assign cfg.dischg_cap = bank_reg[3][7:4];
   assign cfg.term_cur   = bank_reg[3][3:0];
   assign cfg.volt_ctl   = bank_reg[4];
   assign cfg.timer_ctl  = bank_reg[5];
   assign cfg.misc_ctl   = bank_reg[6];
   assign cfg.sys_reg    = bank_reg[7];
   assign cfg.fault_ctl  = bank_reg[9];

   chk_por_values: assert property (@(posedge clk) disable iff (!reset_n)
      first_reg |-> bank_reg[0] == 8'h9f && bank_reg[1] == 8'hac && bank_reg[6] == 8'hc0)
      else $error("power-on defaults wrong");
   chk_restore_all: assert property (@(posedge clk) disable iff (!reset_n)
      restore_go |=> bank_reg[0] == 8'h9f && bank_reg[2] == 8'h0f && bank_reg[3] == 8'h91)
      else $error("restore left a field");
   chk_wd_spares: assert property (@(posedge clk) disable iff (!reset_n)
      watchdog_expiry && !restore_go |=> bank_reg[0] == $past(bank_reg[0])
         && bank_reg[1] == 8'hac)
      else $error("watchdog reset wrong fields");
   chk_wd_restart: assert property (@(posedge clk) disable iff (!reset_n)
      wr_go_reg && wr_ptr_reg == 8'h02 && wr_data_reg[6] |=> wd_restart ##1 !wd_restart)
      else $error("restart pulse missing");
   chk_self_clear: assert property (@(posedge clk) disable iff (!reset_n)
      bank_reg[2][7:6] == 2'b00)
      else $error("action bit stored");
   chk_icc_range: assert property (@(posedge clk) disable iff (!reset_n)
      bank_reg[2][5:0] <= 6'h38)
      else $error("fast charge code out of range");
   chk_dsc_valid: assert property (@(posedge clk) disable iff (!reset_n)
      bank_reg[3][7:4] != 4'h0)
      else $error("discharge cap code zero");
   chk_status_ro: assert property (@(posedge clk) disable iff (!reset_n)
      !first_reg |-> bank_reg[8] == $past(sys_status))
      else $error("status byte not read only");
   chk_write_store: assert property (@(posedge clk) disable iff (!reset_n)
      wr_go_reg && wr_ptr_reg == 8'h01 && !watchdog_expiry |=> bank_reg[1] == $past(wr_data_reg))
      else $error("power-on byte not stored");
   chk_addr_ack: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg == ST_DEV && scl_fall && !start_c && !stop_c && cnt_reg == 4'h8
         && sh_reg[7:1] == SLAVE_ADDR |=> state_reg == ST_DEV_ACK && !sda_oe_n)
      else $error("address not acknowledged");
   chk_stop_idle: assert property (@(posedge clk) disable iff (!reset_n)
      stop_c |=> state_reg == ST_IDLE && sda_oe_n)
      else $error("stop did not release the bus");
   chk_rd_ack_free: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg == ST_RD_ACK |-> sda_oe_n)
      else $error("data held during master ack");
   chk_dis_lift: assert property (@(posedge clk) disable iff (!reset_n)
      wr_go_reg && wr_ptr_reg == 8'h03 && wr_data_reg[7:4] == 4'h0 && !watchdog_expiry
         |=> bank_reg[3][7:4] == 4'h1)
      else $error("zero discharge code stored");
   chk_restore_more: assert property (@(posedge clk) disable iff (!reset_n)
      restore_go |=> bank_reg[1] == 8'hac && bank_reg[4] == 8'ha3)
      else $error("restore missed a register");
endmodule : ccr_config_bank

// ---- ccr_pkg.sv ----
package ccr_pkg;
   localparam logic [7:0] CCR_A_INPUT  = 8'h00;
   localparam logic [7:0] CCR_A_PWRON  = 8'h01;
   localparam logic [7:0] CCR_A_CHG    = 8'h02;
   localparam logic [7:0] CCR_A_DIS    = 8'h03;
   localparam logic [7:0] CCR_A_STATUS = 8'h08;
   localparam logic [7:0] CCR_A_FAULT  = 8'h09;
   localparam logic [7:0] CCR_A_ADDR   = 8'h0a;
   localparam int         CCR_NREG     = 10;
   localparam logic [7:0] CCR_ADDR_VAL = 8'he0;
   localparam logic [7:0] CCR_POR [0:9] = '{8'h9f, 8'hac, 8'h0f, 8'h91, 8'ha3,
                                            8'h3a, 8'hc0, 8'h39, 8'h40, 8'h00};
   // fields a watchdog expiry returns to default
   localparam logic [7:0] CCR_WD_MASK [0:9] = '{8'h00, 8'hff, 8'h7f, 8'hff, 8'hff,
                                                8'h1f, 8'hdf, 8'h00, 8'h00, 8'h00};
   localparam int         CCR_RST_BIT  = 7;
   localparam int         CCR_WDR_BIT  = 6;
   localparam logic [5:0] CCR_ICC_MAX  = 6'h38;
   localparam logic [3:0] CCR_DSC_MIN  = 4'h1;
   localparam logic [3:0] CCR_BITS     = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_DEV     = 4'b0001,
      ST_DEV_ACK = 4'b0010,
      ST_PTR     = 4'b0011,
      ST_PTR_ACK = 4'b0100,
      ST_WR      = 4'b0101,
      ST_WR_ACK  = 4'b0110,
      ST_RD      = 4'b0111,
      ST_RD_ACK  = 4'b1000
   } ccr_state_e;

   typedef struct packed {
      logic [3:0] vin_floor;
      logic [3:0] iin_cap;
      logic [1:0] disc_hold;
      logic       off_time;
      logic       input_high_impedance_enable;
      logic       charge_inhibit;
      logic [2:0] battery_undervoltage_threshold;
      logic [5:0] fast_chg;
      logic [3:0] dischg_cap;
      logic [3:0] term_cur;
      logic [7:0] volt_ctl;
      logic [7:0] timer_ctl;
      logic [7:0] misc_ctl;
      logic [7:0] sys_reg;
      logic [7:0] fault_ctl;
   } ccr_cfg_s;
endpackage : ccr_pkg

// ---- ccr_host_model.sv ----
`timescale 1ns/100ps
module ccr_host_model (
   input  wire logic clk,       // bench clock
   input  wire logic sda_line,  // resolved data wire
   output logic      scl,       // serial clock, idle high
   output logic      sda_drv_n  // low pulls data low
);
   initial begin
      scl = 1'b1;
      sda_drv_n = 1'b1;
   end

   // four clocks a phase keeps each level well above two samples
   task automatic gap();
      repeat (4) @(posedge clk);
   endtask : gap

   task automatic bit_io(input logic b, output logic s);
      sda_drv_n <= b;
      gap();
      scl <= 1'b1;
      gap();
      s = sda_line;
      gap();
      scl <= 1'b0;
      gap();
   endtask : bit_io

   task automatic start();
      sda_drv_n <= 1'b1;
      gap();
      scl <= 1'b1;
      gap();
      sda_drv_n <= 1'b0;
      gap();
      scl <= 1'b0;
      gap();
   endtask : start

   // clock parks high again so it stands still between frames
   task automatic stop();
      sda_drv_n <= 1'b0;
      gap();
      scl <= 1'b1;
      gap();
      sda_drv_n <= 1'b1;
      gap();
   endtask : stop

   task automatic send(input logic [7:0] d, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, nack);
   endtask : send

   task automatic recv(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask : recv
endmodule : ccr_host_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
   import ccr_pkg::*;
   localparam logic [6:0] DEV = 7'h2a; // arbitrary value
   logic       clk             = 1'b0;
   logic       reset_n         = 1'b0;
   logic       watchdog_expiry = 1'b0;
   logic [7:0] sys_status      = 8'h40;
   logic       scl, sda_drv_n, sda_out, sda_oe_n, wd_restart, nk;
   wire        sda_line = sda_drv_n & (sda_oe_n | sda_out);
   ccr_cfg_s   cfg;
   int         mismatches  = 0;
   int         check_count = 0;
   int         wd_seen     = 0;
   logic [7:0] rd [0:10];

   always #4 clk = ~clk;

   ccr_config_bank #(.SLAVE_ADDR(DEV)) uut (
      .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .watchdog_expiry(watchdog_expiry),
      .sys_status(sys_status), .cfg(cfg), .wd_restart(wd_restart));
   ccr_host_model m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv_n(sda_drv_n));

   always @(posedge clk) if (wd_restart === 1'b1) wd_seen <= wd_seen + 1;

   task automatic final_report();
      if (mismatches == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [79:0] got, input logic [79:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
      logic n;
      m.start();
      m.send({DEV, 1'b0}, n);
      check(n, 1'b0);
      m.send(a, n);
      foreach (d[i]) m.send(d[i], n);
      m.stop();
   endtask : wr

   task automatic rdb(input logic [7:0] a, input int cnt);
      logic n;
      m.start();
      m.send({DEV, 1'b0}, n);
      m.send(a, n);
      m.start();
      m.send({DEV, 1'b1}, n);
      for (int i = 0; i < cnt; i++) m.recv(i == cnt - 1, rd[i]);
      m.stop();
   endtask : rdb

   task automatic cmp_rd(input logic [7:0] e [$]);
      foreach (e[i]) check(rd[i], e[i]);
   endtask : cmp_rd

   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdb(8'h00, 11);
      cmp_rd('{8'h9f, 8'hac, 8'h0f, 8'h91, 8'ha3, 8'h3a, 8'hc0, 8'h39, 8'h40, 8'h00,
               8'he0});
      check(cfg, {4'h9, 4'hf, 2'b10, 1'b1, 1'b0, 1'b1, 3'b100, 6'h0f, 4'h9, 4'h1,
                  8'ha3, 8'h3a, 8'hc0, 8'h39, 8'h00});
      wr(8'h01, '{8'h00});
      check(cfg.charge_inhibit, 1'b0);
      // code 0x3f clamps, discharge code zero lifts to one
      wr(8'h00, '{8'h5a, 8'h53, 8'h3f, 8'h07});
      rdb(8'h00, 4);
      cmp_rd('{8'h5a, 8'h53, 8'h38, 8'h17});
      check({cfg.disc_hold, cfg.off_time, cfg.input_high_impedance_enable}, 4'b0101);
      check(cfg.battery_undervoltage_threshold, 3'b011);
      sys_status <= 8'h5a;
      wr(8'h08, '{8'hff, 8'h66, 8'h11});
      rdb(8'h08, 5);
      cmp_rd('{8'h5a, 8'h66, 8'he0, 8'h00, 8'h00});
      check(cfg.fault_ctl, 8'h66);
      @(posedge clk) watchdog_expiry <= 1'b1;
      @(posedge clk) watchdog_expiry <= 1'b0;
      rdb(8'h00, 4);
      cmp_rd('{8'h5a, 8'hac, 8'h0f, 8'h91});
      wr(8'h02, '{8'h45});
      check(wd_seen, 1);
      rdb(8'h02, 1);
      check(rd[0], 8'h05);
      wr(8'h02, '{8'h80});
      rdb(8'h00, 4);
      cmp_rd('{8'h9f, 8'hac, 8'h0f, 8'h91});
      m.start();
      m.send({7'h2b, 1'b0}, nk);
      check(nk, 1'b1);
      m.stop();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      final_report();
   end
endmodule : tb
